// ===== design/buffer_state_control_regs.vh
// State codes, field selects and copy timing for the message buffer block
`ifndef BUFFER_STATE_CONTROL_REGS_VH
`define BUFFER_STATE_CONTROL_REGS_VH

// Four-bit state codes; bit 0 is the hardware busy flag
`define ST_RX_IDLE        4'h0
`define ST_RX_ARMED       4'h2
`define ST_RX_HOLDING     4'h4
`define ST_RX_OVERWRITTEN 4'h6
`define ST_TX_IDLE        4'h8
`define ST_TX_AWAIT       4'ha
`define ST_TX_SINGLE      4'hc
`define ST_TX_SEND_AWAIT  4'he

// Field positions inside the state code
`define ST_BUSY_BIT       0
`define ST_TX_BIT         3

// CPU field selects
`define FLD_STATE         2'h0
`define FLD_ID            2'h1
`define FLD_DLC           2'h2
`define FLD_DATA          2'h3

// Buffer numbering
`define NUM_BUFS          15
`define BASIC_BUF         4'he
`define NO_BUF            4'hf

// Copy from staging to message buffer, in clk_sys cycles
`define COPY_CYCLES       5'h11

// Copy engine states
`define CS_IDLE           2'h0
`define CS_RECV           2'h1
`define CS_WAIT           2'h2
`define CS_COPY           2'h3

`endif

// ===== design/buffer_state_control.v
// Message buffer state control: staging, copy, receive and transmit states
`timescale 1ns/10ps
// Notes on behaviour
// (RULE1) Dominant bit starts reception; frame staged when global or basic filter matches.
// (RULE2) After data, received identifier is compared against buffers 0 to 14.
// (RULE3) Copy into the chosen buffer starts only at the sixth end-of-frame bit.
// (RULE4) Each copy lasts at least 17 clock cycles whatever the length.
// (RULE5) Busy bit 0 of the target state is set during copy, cleared after.
// (RULE6) Copy into armed gives holding; another copy before re-arm gives overwritten.
// (RULE7) While busy, CPU writes to that buffer are blocked except the state.
// (RULE8) State writes during copy resolve: armed->holding, idle->idle, holding->overwritten.
// (RULE9) Software arms a buffer by writing 0010b over 0000b; frames then accepted.
// (RULE10) Copy into holding 0100b shows 0101b during copy, then overwritten.
// (RULE11) State bit 3 set means transmit buffer, clear means receive buffer.
// (RULE12) Software loads a tx_idle buffer fully, then writes tx_single to send.
// (RULE13) Sending buffer reports in-flight; success returns it to tx_idle.
// (RULE14) Failed sends stay in flight and retry until success or cancel.
// (RULE15) Successful remote-request send with tx_single moves buffer to rx_armed.
// (RULE16) Software masks the remote-request bit so the answer frame is accepted.
// (RULE17) Matching remote frame turns tx_await_remote into send-then-await, sends, returns.
// (RULE18) Writing send-then-await sends at once, then waits as tx_await_remote.
// (RULE19) Software sets masks, then identifier, then writes rx_armed.
// (RULE20) Armed buffer with interrupt enabled signals on entering holding.
// (RULE21) Unlocked read: arm, read, wait busy, restart if new data arrived.
// (RULE22) Locked read: read contents, write rx_armed, clear pending bit.
// (RULE23) With lock enabled a holding buffer takes no frame until re-armed.
// (RULE24) Buffers 0 to 13 searched in ascending order, buffer 14 last.
// (RULE25) Send-then-await is 1110b, 1111b sending; 1010b only waits.
// (RULE26) Idle and transmit buffers never take a received data frame.
// (RULE27) CPU writes to the busy bit are ignored.
`include "buffer_state_control_regs.vh"

module buffer_state_control #(
  parameter ID_W   = 29,
  parameter DATA_W = 64
) (
  // Clock, reset, enable
  input  wire                clk_sys,
  input  wire                reset,
  input  wire                clk_en,
  // Receive side of the protocol engine
  input  wire                rx_sof,
  input  wire                rx_frame_done,
  input  wire                rx_eof6,
  input  wire [ID_W-1:0]     rx_id,
  input  wire                rx_rtr,
  input  wire [3:0]          rx_dlc,
  input  wire [DATA_W-1:0]   rx_data,
  // Filter configuration
  input  wire [ID_W:0]       global_filter_mask,
  input  wire [ID_W:0]       basic_filter_mask,
  input  wire                receive_lock_enable,
  input  wire [14:0]         rx_irq_enable,
  // CPU access
  input  wire                cpu_wr,
  input  wire [3:0]          cpu_buf,
  input  wire [1:0]          cpu_field,
  input  wire [DATA_W-1:0]   cpu_wdata,
  // Transmit side of the protocol engine
  input  wire                tx_done,
  input  wire                tx_fail,
  // Read-back of the selected buffer
  output reg  [3:0]          rd_state_r,
  output reg  [ID_W:0]       rd_id_r,
  output reg  [3:0]          rd_dlc_r,
  output reg  [DATA_W-1:0]   rd_data_r,
  // Status and transmit request
  output reg                 copy_busy_r,
  output reg  [14:0]         rx_event_r,
  output reg                 tx_req_r,
  output reg  [3:0]          tx_buf_r
);

  localparam KEY_W = ID_W + 1;

  // Buffer contents
  reg  [3:0]        st_r   [0:14];
  reg  [3:0]        st_nxt [0:14];
  reg  [KEY_W-1:0]  id_r   [0:14];
  reg  [3:0]        dlc_r  [0:14];
  reg  [DATA_W-1:0] data_r [0:14];

  // Staging buffer and copy engine
  reg  [1:0]        cs_r;
  reg  [KEY_W-1:0]  hid_key_r;
  reg  [3:0]        hid_dlc_r;
  reg  [DATA_W-1:0] hid_data_r;
  reg  [3:0]        tgt_r;
  reg  [4:0]        cnt_r;
  reg               tx_active_r;

  wire [14:0]       filt_hit;
  wire [14:0]       rx_cand;
  wire [14:0]       remote_hit;
  wire [14:0]       tx_pend;
  wire [14:0]       key_hit;
  wire [KEY_W-1:0]  rx_key;
  wire [3:0]        low_sel;
  wire [3:0]        rx_sel;
  wire [3:0]        tx_sel;
  wire              copy_start;
  wire              remote_go;
  wire              copy_end;
  wire              tx_start;
  wire              cpu_ok;

  integer i;

  // Masked compare: set mask bits are don't care
  function match_key;
    input [KEY_W-1:0] a;
    input [KEY_W-1:0] b;
    input [KEY_W-1:0] m;
    begin
      match_key = ((a ^ b) & ~m) == {KEY_W{1'b0}};
    end
  endfunction

  // Lowest set bit wins; none gives the no-buffer code
  function [3:0] first_set;
    input [14:0] v;
    integer k;
    begin
      first_set = `NO_BUF;
      for (k = 14; k >= 0; k = k - 1)
        if (v[k])
          first_set = k[3:0];
    end
  endfunction

  assign rx_key = {rx_id, rx_rtr};
  assign cpu_ok = cpu_wr && (cpu_buf != `NO_BUF);

  genvar g;
  generate
    for (g = 0; g < `NUM_BUFS; g = g + 1)
    begin : g_buf
      // Buffer 14 filters with the basic mask, others with the global one
      assign filt_hit[g] = match_key(hid_key_r, id_r[g],
                           (g == 14) ? basic_filter_mask
                                     : global_filter_mask);
      assign key_hit[g]  = match_key(rx_key, id_r[g],
                           (g == 14) ? basic_filter_mask
                                     : global_filter_mask);
      // Idle, transmit and locked buffers are skipped
      assign rx_cand[g] = filt_hit[g] && !st_r[g][`ST_TX_BIT] &&
                          (st_r[g][3:1] != 3'h0) &&
                          !(receive_lock_enable &&
                            st_r[g][2]); // [RULE26] [RULE23] [RULE11]
      assign remote_hit[g] = filt_hit[g] && hid_key_r[0] &&
                             (st_r[g] == `ST_TX_AWAIT); // [RULE17]
      assign tx_pend[g] = (st_r[g] == `ST_TX_SINGLE) ||
                          (st_r[g] == `ST_TX_SEND_AWAIT);
    end
  endgenerate

  // Buffers 0..13 first; buffer 14 only if none of them took it
  assign low_sel = first_set({1'b0, rx_cand[13:0]}); // [RULE24]
  assign rx_sel  = (low_sel != `NO_BUF) ? low_sel :
                   (rx_cand[14] ? `BASIC_BUF : `NO_BUF);
  assign tx_sel  = first_set(tx_pend);

  assign copy_start = (cs_r == `CS_WAIT) && rx_eof6 &&
                      (rx_sel != `NO_BUF); // [RULE3]
  // Remote frames trigger answers even when no receive buffer takes them
  assign remote_go  = (cs_r == `CS_WAIT) && rx_eof6; // [RULE17]
  assign copy_end   = (cs_r == `CS_COPY) && (cnt_r == 5'h01); // [RULE4]
  assign tx_start   = !tx_active_r && (tx_sel != `NO_BUF);

  // Next state code of every buffer
  always @*
  begin
    for (i = 0; i < `NUM_BUFS; i = i + 1)
    begin
      st_nxt[i] = st_r[i];
      if (cpu_ok && cpu_field == `FLD_STATE && cpu_buf == i[3:0])
      begin
        // Busy flag stays under hardware control, except that writing a different state to a sending buffer clears it
        if (st_r[i][`ST_BUSY_BIT] && !st_r[i][`ST_TX_BIT])
          st_nxt[i] = {cpu_wdata[3:1], 1'b1}; // [RULE8] [RULE27]
        else if (st_r[i][`ST_BUSY_BIT] &&
                 cpu_wdata[3:1] == st_r[i][3:1])
          st_nxt[i] = st_r[i]; // [RULE27]
        else
          st_nxt[i] = {cpu_wdata[3:1], 1'b0}; // [RULE9] [RULE14]
      end
      if (copy_start && rx_sel == i[3:0])
        st_nxt[i][`ST_BUSY_BIT] = 1'b1; // [RULE5] [RULE10]
      if (copy_end && tgt_r == i[3:0])
      begin
        case (st_nxt[i][3:1])
          3'h1:    st_nxt[i] = `ST_RX_HOLDING; // [RULE6] [RULE8]
          3'h2:    st_nxt[i] = `ST_RX_OVERWRITTEN; // [RULE6] [RULE10]
          3'h3:    st_nxt[i] = `ST_RX_OVERWRITTEN;
          default: st_nxt[i] = {st_nxt[i][3:1], 1'b0}; // [RULE5]
        endcase
      end
      if (remote_go && remote_hit[i] && st_nxt[i] == `ST_TX_AWAIT)
        st_nxt[i] = `ST_TX_SEND_AWAIT; // [RULE17]
      if (tx_start && tx_sel == i[3:0] && st_nxt[i] == st_r[i])
        st_nxt[i][`ST_BUSY_BIT] = 1'b1; // [RULE13] [RULE25]
      if (tx_active_r && tx_done && tx_buf_r == i[3:0])
      begin
        if (st_nxt[i] == (`ST_TX_SINGLE | 4'h1))
          st_nxt[i] = id_r[i][0] ? `ST_RX_ARMED
                                 : `ST_TX_IDLE; // [RULE13] [RULE15]
        else if (st_nxt[i] == (`ST_TX_SEND_AWAIT | 4'h1))
          st_nxt[i] = `ST_TX_AWAIT; // [RULE18] [RULE17] [RULE25]
      end
    end
  end

  // Buffer storage and state codes
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (i = 0; i < `NUM_BUFS; i = i + 1)
      begin
        st_r[i]   <= `ST_RX_IDLE;
        id_r[i]   <= {KEY_W{1'b0}};
        dlc_r[i]  <= 4'h0;
        data_r[i] <= {DATA_W{1'b0}};
      end
    end
    else if (clk_en)
    begin
      for (i = 0; i < `NUM_BUFS; i = i + 1)
        st_r[i] <= st_nxt[i];
      // Contents are locked while the busy flag is up
      if (cpu_ok && !st_r[cpu_buf][`ST_BUSY_BIT]) // [RULE7]
      begin
        case (cpu_field)
          `FLD_ID:   id_r[cpu_buf]   <= cpu_wdata[KEY_W-1:0];
          `FLD_DLC:  dlc_r[cpu_buf]  <= cpu_wdata[3:0];
          `FLD_DATA: data_r[cpu_buf] <= cpu_wdata;
          default:   ;
        endcase
      end
      if (copy_end)
      begin
        id_r[tgt_r]   <= hid_key_r;
        dlc_r[tgt_r]  <= hid_dlc_r;
        data_r[tgt_r] <= hid_data_r;
      end
    end
  end

  // Staging buffer and copy sequencer
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      cs_r       <= `CS_IDLE;
      hid_key_r  <= {KEY_W{1'b0}};
      hid_dlc_r  <= 4'h0;
      hid_data_r <= {DATA_W{1'b0}};
      tgt_r      <= `NO_BUF;
      cnt_r      <= 5'h00;
      rx_event_r <= 15'h0000;
    end
    else if (clk_en)
    begin
      rx_event_r <= 15'h0000;
      case (cs_r)
        `CS_IDLE:
          if (rx_sof)
            cs_r <= `CS_RECV; // [RULE1]
        `CS_RECV:
          if (rx_frame_done)
          begin
            // Stage only if some filter path accepts it
            if (key_hit != 15'h0000) // [RULE1] [RULE2]
            begin
              hid_key_r  <= rx_key;
              hid_dlc_r  <= rx_dlc;
              hid_data_r <= rx_data;
              cs_r       <= `CS_WAIT;
            end
            else
              cs_r <= `CS_IDLE;
          end
        `CS_WAIT:
          if (rx_eof6)
          begin
            if (rx_sel != `NO_BUF)
            begin
              tgt_r <= rx_sel;
              cnt_r <= `COPY_CYCLES; // [RULE4]
              cs_r  <= `CS_COPY;
            end
            else
              cs_r <= `CS_IDLE;
          end
          else if (rx_sof)
            cs_r <= `CS_RECV;
        `CS_COPY:
        begin
          cnt_r <= cnt_r - 5'h01;
          if (copy_end)
          begin
            if (st_r[tgt_r][3:1] == 3'h1 && rx_irq_enable[tgt_r])
              rx_event_r[tgt_r] <= 1'b1; // [RULE20]
            cs_r <= rx_sof ? `CS_RECV : `CS_IDLE;
          end
        end
        default:
          cs_r <= `CS_IDLE;
      endcase
    end
  end

  // Transmit request towards the protocol engine
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_active_r <= 1'b0;
      tx_req_r    <= 1'b0;
      tx_buf_r    <= `NO_BUF;
    end
    else if (clk_en)
    begin
      if (tx_start)
      begin
        tx_active_r <= 1'b1;
        tx_req_r    <= 1'b1;
        tx_buf_r    <= tx_sel;
      end
      // Failure keeps the request up for retry; cancel drops it
      else if (tx_active_r &&
               (tx_done || !st_nxt[tx_buf_r][`ST_BUSY_BIT]))
      begin
        tx_active_r <= 1'b0; // [RULE14]
        tx_req_r    <= 1'b0;
      end
      else if (tx_active_r && tx_fail)
        tx_req_r <= 1'b1; // [RULE14]
    end
  end

  // Registered read-back and busy status
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_state_r  <= 4'h0;
      rd_id_r     <= {KEY_W{1'b0}};
      rd_dlc_r    <= 4'h0;
      rd_data_r   <= {DATA_W{1'b0}};
      copy_busy_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cpu_buf != `NO_BUF)
      begin
        rd_state_r <= st_nxt[cpu_buf];
        rd_id_r    <= id_r[cpu_buf];
        rd_dlc_r   <= dlc_r[cpu_buf];
        rd_data_r  <= data_r[cpu_buf];
      end
      else
      begin
        rd_state_r <= 4'h0;
        rd_id_r    <= {KEY_W{1'b0}};
        rd_dlc_r   <= 4'h0;
        rd_data_r  <= {DATA_W{1'b0}};
      end
      copy_busy_r <= copy_start || (cs_r == `CS_COPY && !copy_end);
    end
  end

endmodule

// ===== tb/buffer_state_control_checker.sv
// Assertion checker for the message buffer state block
`timescale 1ns/10ps
module buffer_state_control_checker (
  // Clock and reset
  input logic        clk_sys,
  input logic        reset,
  input logic        clk_en,
  // Inputs that steer outputs
  input logic        cpu_wr,
  input logic [3:0]  cpu_buf,
  input logic        tx_done,
  input logic [14:0] rx_irq_enable,
  // Watched outputs
  input logic        copy_busy_r,
  input logic [14:0] rx_event_r,
  input logic        tx_req_r,
  input logic [3:0]  tx_buf_r,
  input logic [3:0]  rd_state_r
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_copy_min;
    $rose(copy_busy_r) |-> copy_busy_r[*8] ##1 copy_busy_r[*8];
  endproperty
  a_copy_min: assert property (p_copy_min)
    else $error("copy too short");
  property p_copy_end;
    $rose(copy_busy_r) |-> ##[16:24] !copy_busy_r;
  endproperty
  a_copy_end: assert property (p_copy_end)
    else $error("copy never ends");
  property p_ev_end;
    rx_event_r != 15'h0 |-> $fell(copy_busy_r);
  endproperty
  a_ev_end: assert property (p_ev_end)
    else $error("event outside copy end");
  property p_ev_pulse;
    rx_event_r != 15'h0 |=> rx_event_r == 15'h0;
  endproperty
  a_ev_pulse: assert property (p_ev_pulse)
    else $error("event too long");
  property p_ev_en;
    rx_event_r != 15'h0 |-> (rx_event_r & ~$past(rx_irq_enable)) == 15'h0;
  endproperty
  a_ev_en: assert property (p_ev_en)
    else $error("event while disabled");
  property p_tx_hold;
    clk_en && tx_req_r && !tx_done && !cpu_wr |=> tx_req_r;
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("request dropped");
  property p_tx_drop;
    clk_en && tx_req_r && tx_done |-> ##[1:2] !tx_req_r;
  endproperty
  a_tx_drop: assert property (p_tx_drop)
    else $error("request kept after done");
  property p_tx_busy;
    tx_req_r && !$past(cpu_wr) && $past(cpu_buf) == tx_buf_r
      |-> rd_state_r[3] && rd_state_r[0];
  endproperty
  a_tx_busy: assert property (p_tx_busy)
    else $error("sending buffer not busy");
endmodule

// ===== tb/can_node_model.sv
// Far-side engine model: frames received and transmit outcome
`timescale 1ns/10ps
module can_node_model (
  // Clock and transmit handshake
  input  logic        clk_sys,
  input  logic        tx_req_r,
  input  logic        fail_once,
  output logic        tx_done,
  output logic        tx_fail,
  // Received frame
  output logic        rx_sof,
  output logic        rx_frame_done,
  output logic        rx_eof6,
  output logic [28:0] rx_id,
  output logic        rx_rtr,
  output logic [3:0]  rx_dlc,
  output logic [63:0] rx_data
);
  initial
  begin
    {rx_sof, rx_frame_done, rx_eof6, tx_done, tx_fail} = 5'h0;
    {rx_id, rx_rtr, rx_dlc, rx_data} = '1;
  end

  task automatic rx_go(input logic [28:0] id, input logic rtr,
                       input logic [63:0] d);
    @(posedge clk_sys) #1 rx_sof = 1'b1;
    @(posedge clk_sys) #1 rx_sof = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 {rx_id, rx_rtr, rx_dlc, rx_data} = {id, rtr, 4'h8, d};
    rx_frame_done = 1'b1;
    @(posedge clk_sys) #1 rx_frame_done = 1'b0;
    // Stale lines would hide a late capture
    {rx_id, rx_rtr, rx_data} = ~{id, rtr, d};
    repeat (14) @(posedge clk_sys);
    #1 rx_eof6 = 1'b1;
    @(posedge clk_sys) #1 rx_eof6 = 1'b0;
  endtask

  // Slow answer; one lost attempt only when asked
  initial
  forever
  begin
    @(posedge clk_sys) #1;
    if (tx_req_r === 1'b1)
    begin
      repeat (3) @(posedge clk_sys);
      #1 tx_fail = fail_once;
      @(posedge clk_sys) #1 tx_fail = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 tx_done = 1'b1;
      @(posedge clk_sys) #1 tx_done = 1'b0;
      while (tx_req_r !== 1'b0)
        @(posedge clk_sys) #1;
    end
  end
endmodule

// ===== tb/testbench.sv
// Bench for the message buffer state block
`timescale 1ns/10ps
`include "buffer_state_control_regs.vh"
module testbench;
  logic        clk_sys, reset, clk_en, cpu_wr, fail_once, rx_sof;
  logic        rx_frame_done, rx_eof6, rx_rtr, tx_done, tx_fail;
  logic        receive_lock_enable, copy_busy_r, tx_req_r;
  logic [28:0] rx_id;
  logic [29:0] global_filter_mask, basic_filter_mask, rd_id_r;
  logic [3:0]  rx_dlc, cpu_buf, rd_state_r, rd_dlc_r, tx_buf_r, b;
  logic [1:0]  cpu_field;
  logic [63:0] rx_data, cpu_wdata, rd_data_r;
  logic [14:0] rx_irq_enable, rx_event_r;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  localparam logic [28:0] id1 = 29'h0123;
  localparam logic [28:0] id2 = 29'h0200;
  localparam logic [63:0] d1 = 64'h0123456789abcdef;
  localparam logic [63:0] k1 = {34'h0, id1, 1'b0};
  localparam logic [3:0]  fin [3] = '{4'h8, 4'h2, 4'ha};

  buffer_state_control i_dut (.clk_sys, .reset, .clk_en, .rx_sof,
    .rx_frame_done, .rx_eof6, .rx_id, .rx_rtr, .rx_dlc, .rx_data,
    .global_filter_mask, .basic_filter_mask, .receive_lock_enable,
    .rx_irq_enable, .cpu_wr, .cpu_buf, .cpu_field, .cpu_wdata, .tx_done,
    .tx_fail, .rd_state_r, .rd_id_r, .rd_dlc_r, .rd_data_r, .copy_busy_r,
    .rx_event_r, .tx_req_r, .tx_buf_r);
  can_node_model i_node (.clk_sys, .tx_req_r, .fail_once, .tx_done,
    .tx_fail, .rx_sof, .rx_frame_done, .rx_eof6, .rx_id, .rx_rtr,
    .rx_dlc, .rx_data);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] n, input logic [1:0] f,
                    input logic [63:0] v);
    @(posedge clk_sys) #1;
    {cpu_buf, cpu_field, cpu_wdata} = {n, f, v};
    cpu_wr = 1'b1;
    @(posedge clk_sys) #1 cpu_wr = 1'b0;
  endtask

  task automatic cs(input logic [3:0] n, input logic [3:0] exp);
    @(posedge clk_sys) #1 cpu_buf = n;
    @(posedge clk_sys) #1;
    cmp(rd_state_r, exp);
  endtask

  task automatic wait_req(input logic [3:0] n);
    for (int i = 0; i < 40 && tx_req_r !== 1'b1; i++)
      @(posedge clk_sys) #1;
    cmp({tx_req_r, tx_buf_r}, {1'b1, n});
  endtask

  // Waits for both copy and send to finish
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 60 && (tx_req_r | copy_busy_r) !== 1'b0; i++)
      @(posedge clk_sys) #1;
  endtask

  initial
  begin
    {reset, clk_en, cpu_wr, fail_once, receive_lock_enable} = 5'h18;
    {global_filter_mask, basic_filter_mask} = 60'h0;
    rx_irq_enable = 15'h0004;
    {cpu_buf, cpu_field, cpu_wdata} = {4'hf, 2'h0, 64'h0};
    repeat (3) @(posedge clk_sys);
    #1 reset = 1'b0;
    cs(4'h0, `ST_RX_IDLE);
    wr(4'h0, `FLD_ID, k1);
    wr(4'h2, `FLD_ID, k1);
    wr(4'h5, `FLD_ID, k1);
    wr(4'h2, `FLD_STATE, `ST_RX_ARMED);
    wr(4'h5, `FLD_STATE, `ST_RX_ARMED);
    i_node.rx_go(id1, 1'b0, d1);
    cs(4'h2, 4'h3);
    for (int i = 0; i < 30 && rx_event_r !== 15'h0004; i++)
      @(posedge clk_sys) #1;
    cmp(rx_event_r, 15'h0004);
    cs(4'h2, `ST_RX_HOLDING);
    cmp(rd_data_r, d1);
    cmp(rd_id_r, k1);
    cmp(rd_dlc_r, 4'h8);
    cs(4'h5, `ST_RX_ARMED);
    cs(4'h0, `ST_RX_IDLE);
    i_node.rx_go(id1, 1'b0, ~d1);
    cs(4'h2, 4'h5);
    settle();
    cs(4'h2, `ST_RX_OVERWRITTEN);
    cmp(rd_data_r, ~d1);
    receive_lock_enable = 1'b1;
    i_node.rx_go(id1, 1'b0, d1);
    wr(4'h5, `FLD_STATE, `ST_RX_IDLE);
    settle();
    cs(4'h5, `ST_RX_IDLE);
    cs(4'h2, `ST_RX_OVERWRITTEN);
    cmp(rd_data_r, ~d1);
    receive_lock_enable = 1'b0;
    wr(4'hb, `FLD_STATE, 4'h9);
    cs(4'hb, `ST_TX_IDLE);
    wr(4'ha, `FLD_STATE, `ST_TX_AWAIT);
    cs(4'ha, `ST_TX_AWAIT);
    cmp(tx_req_r, 1'b0);
    // Single send with one loss, remote request, send then await
    for (int i = 0; i < 3; i++)
    begin
      b = 4'h7 + i[3:0];
      fail_once = (i == 0);
      wr(b, `FLD_STATE, `ST_TX_IDLE);
      wr(b, `FLD_ID, {34'h0, id2 + i[28:0], i == 1});
      wr(b, `FLD_STATE, i == 2 ? `ST_TX_SEND_AWAIT : `ST_TX_SINGLE);
      wait_req(b);
      cs(b, i == 2 ? 4'hf : 4'hd);
      settle();
      cs(b, fin[i]);
    end
    global_filter_mask = 30'h1;
    i_node.rx_go(id2 + 29'h2, 1'b1, d1);
    wait_req(4'h9);
    cs(4'h9, 4'hf);
    settle();
    cs(4'h9, `ST_TX_AWAIT);
    report_and_stop();
  end
endmodule

bind buffer_state_control buffer_state_control_checker i_chk (.clk_sys,
  .reset, .clk_en, .cpu_wr, .cpu_buf, .tx_done, .rx_irq_enable,
  .copy_busy_r, .rx_event_r, .tx_req_r, .tx_buf_r, .rd_state_r);
